// *** core/bsf_flags.sv ***
// Purpose: status word, error code and identity words of a battery gauge
// Assumes: inputs come from logic on CLOCK; one second tick made inside from SEC_TICK_CYCLES
// Notes:   all state in one struct; one comb and one register process
//
// Summary of operation
// - status word: alarms high, states, error low
// - overcharge alarm set; cleared when charging stops
// - activity timeout equals ten times filter seconds
// - stop charge alarm on bad parameter or termination
// - over temperature alarm at or above limit
// - stop discharge alarm on empty, low voltage
// - capacity alarm below programmed capacity level
// - time alarm below programmed time level
// - loaded flag follows configuration load outcome
// - discharging flag on discharge or no-charge timeout
// - full flag on termination, clears at percentage
// - empty flag on low voltage, clears twenty
// - error zero ok, one when busy
// - error two for reserved or optional codes
// - error three for unsupported standard code
// - error four for write to read only
// - errors five, six, seven for data faults
// - cycle count read, saturating at maximum
// - cycle count advances per threshold charge
// - cycle count written back after each update
// - design capacity read in selected units
// - design voltage read from nonvolatile word
// - alarm broadcast forces error bits high
// - alarm comparisons use current or power
`timescale 1ns/1ns
module bsf_flags
  import bsf_pkg::*;
#(
  parameter int SEC_TICK_CYCLES = CLK_HZ   // cycles per second tick
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire bsf_meas_s   MEAS,
  input  wire bsf_cfg_s    CFG,
  input  wire bsf_cmd_s    CMD,
  input  wire bsf_cls_e    CMD_CLASS,
  input  wire logic [15:0] NV_CYCLE_INIT,
  input  wire logic        NV_INIT_VALID,
  input  wire logic        ALARM_SEND,
  output logic [15:0]      READ_DATA,
  output logic             READ_VALID,
  output logic [15:0]      STATUS_WORD,
  output logic [15:0]      ALARM_WORD,
  output logic             ALARM_VALID,
  output logic             NV_WRITE,
  output logic [7:0]       NV_ADDR,
  output logic [15:0]      NV_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    // timers and counters
    logic [31:0] tick_cnt;        // cycles toward one second
    logic [31:0] idle_sec;        // seconds without any activity
    logic [31:0] nochg_sec;       // seconds without charge activity
    logic [15:0] cycle_count;
    logic [15:0] chg_accum;       // charge units toward one cycle
    // flags
    logic        over_charged;
    logic        stop_charge_alarm;
    logic        over_temp;
    logic        stop_discharge_alarm;
    logic        cap_alarm;
    logic        time_alarm;
    logic        config_loaded_flag;
    logic        discharging;
    logic        full;
    logic        empty;
    logic        charging;        // charge seen since last stop
    // bus replies
    bsf_err_e    err;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] awd;
    logic        avalid;
    // write-back port
    logic        nv_we;
    logic [7:0]  nv_addr;
    logic [15:0] nv_data;
  } bsf_state_s;

  bsf_state_s st_reg;   // registered state
  bsf_state_s st_next;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // status word assembly, used for reads and broadcast
  function automatic logic [15:0] pack_status(input bsf_state_s s);
    logic [15:0] w;
    w = ZERO16;

    w[BIT_OVER_CHARGED] = s.over_charged;
    w[BIT_STOP_CHARGE]  = s.stop_charge_alarm;
    w[BIT_RSVD_HI]      = 1'b0;
    w[BIT_OVER_TEMP]    = s.over_temp;
    w[BIT_STOP_DISCH]   = s.stop_discharge_alarm;
    w[BIT_RSVD_LO]      = 1'b0;
    w[BIT_CAP_ALARM]    = s.cap_alarm;
    w[BIT_TIME_ALARM]   = s.time_alarm;
    w[BIT_LOADED]       = s.config_loaded_flag;
    w[BIT_DISCHARGING]  = s.discharging;
    w[BIT_FULL]         = s.full;
    w[BIT_EMPTY]        = s.empty;
    w[2:0]              = s.err;

    return w;
  endfunction

  // timeout figures in seconds, widened so products never wrap
  logic [31:0] filter_timeout_sec;  // activity timeout
  logic [31:0] nochg_timeout_sec;   // no-charge discharging timeout
  logic        sec_tick;            // one-cycle second pulse
  logic [15:0] cap_now;             // capacity in the selected unit
  logic [15:0] time_now;            // time in the selected unit

  assign filter_timeout_sec = 32'(FILTER_MULT) * 32'(CFG.digital_filter);
  // zero filter would divide by zero; use the largest count, reached only when nochg_sec saturates
  assign nochg_timeout_sec  = (CFG.digital_filter == 8'h00) ? 32'hffffffff :
                              32'(NOACT_NUM) / 32'(CFG.digital_filter);
  assign sec_tick = (st_reg.tick_cnt == 32'(SEC_TICK_CYCLES - 1));

  // unit selection for alarm comparisons
  assign cap_now  = CFG.capacity_mode ? MEAS.remaining_cap_power : MEAS.remaining_charge;
  assign time_now = CFG.capacity_mode ? MEAS.avg_time_power : MEAS.avg_time_current;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        idle_out;     // no activity for filter timeout
    logic        stopped;      // charging has stopped
    logic        low_volt;     // voltage under second empty level
    logic [15:0] cnt_new;

    idle_out = 1'b0;
    stopped  = 1'b0;
    low_volt = 1'b0;
    cnt_new  = ZERO16;
    st_next  = st_reg;

    // one-second timebase
    st_next.tick_cnt = sec_tick ? 32'h0 : st_reg.tick_cnt + 32'h1;

    // activity timers, saturating
    if (MEAS.charge_seen || MEAS.discharge_seen) begin
      st_next.idle_sec = 32'h0;
    end else if (sec_tick && st_reg.idle_sec != 32'hffffffff) begin
      st_next.idle_sec = st_reg.idle_sec + 32'h1;
    end
    if (MEAS.charge_seen) begin
      st_next.nochg_sec = 32'h0;
    end else if (sec_tick && st_reg.nochg_sec != 32'hffffffff) begin
      st_next.nochg_sec = st_reg.nochg_sec + 32'h1;
    end
    idle_out = (st_reg.idle_sec >= filter_timeout_sec);
    stopped  = MEAS.discharge_seen || idle_out;

    // charging memory used by the capacity and time clear terms
    if (MEAS.charge_seen) begin
      st_next.charging = 1'b1;
    end else if (stopped) begin
      st_next.charging = 1'b0;
    end

    // overcharge: set wins while condition holds
    if (MEAS.over_charge_cond) begin
      st_next.over_charged = 1'b1;
    end else if (stopped) begin
      st_next.over_charged = 1'b0;
    end

    // stop charge alarm follows its causes; a stop clears it unless the parameter is bad
    if (MEAS.charge_param_bad || MEAS.charge_terminated) begin
      st_next.stop_charge_alarm = 1'b1;
    end else begin
      st_next.stop_charge_alarm = 1'b0;
    end

    if (stopped && !MEAS.charge_param_bad) begin
      st_next.stop_charge_alarm = 1'b0;
    end

    // temperature alarm is a plain level compare
    st_next.over_temp = (MEAS.temperature >= CFG.max_temperature_limit);

    // stop discharge alarm clears only when all three are false
    st_next.stop_discharge_alarm = (MEAS.remaining_charge == ZERO16) ||
                                   (MEAS.voltage <= CFG.final_empty_voltage) ||
                                   MEAS.cell_low_voltage_flag;

    // capacity alarm; charging also clears
    if (cap_now < CFG.cap_alarm_level && !st_reg.charging) begin
      st_next.cap_alarm = 1'b1;
    end else if (cap_now > CFG.cap_alarm_level || st_reg.charging) begin
      st_next.cap_alarm = 1'b0;
    end

    // time alarm; charging also clears
    if (time_now < CFG.time_alarm_level && !st_reg.charging) begin
      st_next.time_alarm = 1'b1;
    end else if (time_now > CFG.time_alarm_level || st_reg.charging) begin
      st_next.time_alarm = 1'b0;
    end

    // load outcome; a good load wins if both arrive together
    if (MEAS.load_ok) begin
      st_next.config_loaded_flag = 1'b1;
    end else if (MEAS.load_bad) begin
      st_next.config_loaded_flag = 1'b0;
    end

    // discharging state
    if (MEAS.charge_seen) begin
      st_next.discharging = 1'b0;
    end else if (MEAS.discharge_seen || st_reg.nochg_sec >= nochg_timeout_sec) begin
      st_next.discharging = 1'b1;
    end

    // fully charged: set wins over clear
    if (MEAS.charge_terminated || MEAS.over_charge_cond) begin
      st_next.full = 1'b1;
    end else if (MEAS.rel_soc <= CFG.full_clear_pct) begin
      st_next.full = 1'b0;
    end

    // fully discharged
    low_volt = CFG.use_cell_voltage ? (MEAS.cell_voltage < CFG.second_empty_voltage) :
                                      (MEAS.voltage < CFG.second_empty_voltage);
    if ((low_volt && MEAS.current_abs < CFG.overload_current_limit) ||
        MEAS.rel_soc < CFG.battery_low_pct) begin
      st_next.empty = 1'b1;
    end else if (MEAS.rel_soc >= EMPTY_CLEAR_PCT) begin
      st_next.empty = 1'b0;
    end

    // cycle counting and write-back
    st_next.nv_we = 1'b0;

    if (NV_INIT_VALID) begin
      st_next.cycle_count = NV_CYCLE_INIT;
      st_next.chg_accum   = ZERO16;
    end else if (MEAS.charge_increment) begin
      if (st_reg.chg_accum + 16'h1 >= CFG.cycle_thresh) begin
        st_next.chg_accum = ZERO16;
        // stick at the top once reached
        cnt_new = (st_reg.cycle_count == COUNT_SAT) ? COUNT_SAT :
                  st_reg.cycle_count + 16'h1;
        st_next.cycle_count = cnt_new;
        st_next.nv_we   = 1'b1;
        st_next.nv_addr = NV_CYCLE_COUNT;
        st_next.nv_data = cnt_new;
      end else begin
        st_next.chg_accum = st_reg.chg_accum + 16'h1;
      end
    end

    // command handling and error code
    st_next.rvalid = 1'b0;
    if (CMD.valid) begin
      // busy outranks every other code
      if (CMD.busy) begin
        st_next.err = BSF_ERR_BUSY;
      end else if (CMD_CLASS == BSF_CLS_RESERVED || CMD_CLASS == BSF_CLS_MFG_OPT) begin
        st_next.err = BSF_ERR_RESERVED;
      end else if (CMD_CLASS == BSF_CLS_UNSUPP) begin
        st_next.err = BSF_ERR_UNSUPP;
      end else if (CMD.write && CMD_CLASS == BSF_CLS_RO) begin
        st_next.err = BSF_ERR_DENIED;
      end else if (CMD.overflow) begin
        st_next.err = BSF_ERR_OVERFLOW;
      end else if (CMD.write && CMD.size_bad) begin
        st_next.err = BSF_ERR_BADSIZE;
      end else if (CMD.unknown) begin
        st_next.err = BSF_ERR_UNKNOWN;
      end else begin
        st_next.err = BSF_ERR_OK;
      end

      // read words of this block
      if (!CMD.write && !CMD.busy) begin
        unique case (CMD.code)
          CMD_STATUS: begin
            st_next.rdata  = pack_status(st_reg);
            st_next.rvalid = 1'b1;
          end
          CMD_CYCLE_COUNT: begin
            st_next.rdata  = st_reg.cycle_count;
            st_next.rvalid = 1'b1;
          end
          CMD_DESIGN_CAP: begin
            st_next.rdata  = CFG.capacity_mode ? CFG.design_capacity_pwr :
                                                 CFG.design_capacity;
            st_next.rvalid = 1'b1;
          end
          CMD_DESIGN_VOLT: begin
            st_next.rdata  = CFG.design_voltage;
            st_next.rvalid = 1'b1;
          end
          default: begin
            st_next.rdata  = ZERO16;   // other words served elsewhere
          end
        endcase
      end
    end

    // alarm broadcast copy with error bits forced high
    st_next.avalid = ALARM_SEND;
    if (ALARM_SEND) begin
      st_next.awd = pack_status(st_reg) | {13'h0, ERR_ALL};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg      <= '0;
      st_reg.err  <= BSF_ERR_OK;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign READ_DATA   = st_reg.rdata;
  assign READ_VALID  = st_reg.rvalid;

  assign STATUS_WORD = pack_status(st_reg);
  assign ALARM_WORD  = st_reg.awd;
  assign ALARM_VALID = st_reg.avalid;

  assign NV_WRITE    = st_reg.nv_we;
  assign NV_ADDR     = st_reg.nv_addr;
  assign NV_DATA     = st_reg.nv_data;

endmodule // bsf_flags

// *** core/bsf_pkg.sv ***
// Purpose: shared constants and carriers for the battery status flag block
// Assumes: one 100 MHz clock, command words arrive already decoded from the bus engine
// Notes:   bit positions follow the status word layout
package bsf_pkg;
  // status word bit positions
  localparam int BIT_OVER_CHARGED  = 15;
  localparam int BIT_STOP_CHARGE   = 14;
  localparam int BIT_RSVD_HI       = 13;
  localparam int BIT_OVER_TEMP     = 12;
  localparam int BIT_STOP_DISCH    = 11;
  localparam int BIT_RSVD_LO       = 10;
  localparam int BIT_CAP_ALARM     = 9;
  localparam int BIT_TIME_ALARM    = 8;
  localparam int BIT_LOADED        = 7;
  localparam int BIT_DISCHARGING   = 6;
  localparam int BIT_FULL          = 5;
  localparam int BIT_EMPTY         = 4;
  // command codes
  localparam logic [7:0] CMD_STATUS       = 8'h16;
  localparam logic [7:0] CMD_CYCLE_COUNT  = 8'h17;
  localparam logic [7:0] CMD_DESIGN_CAP   = 8'h18;
  localparam logic [7:0] CMD_DESIGN_VOLT  = 8'h19;
  // nonvolatile word addresses
  localparam logic [7:0] NV_CYCLE_COUNT   = 8'h0e;
  localparam logic [7:0] NV_CYCLE_THRESH  = 8'h3c;
  localparam logic [7:0] NV_DESIGN_VOLT   = 8'h12;
  localparam logic [7:0] NV_FULL_CLEAR    = 8'h4c;
  // figures
  localparam logic [15:0] COUNT_SAT       = 16'hffff;
  localparam logic [7:0]  EMPTY_CLEAR_PCT = 8'h14;   // 20 percent
  localparam int          FILTER_MULT     = 10;      // timeout seconds per filter unit
  localparam int          NOACT_NUM       = 22500;   // no-charge seconds numerator
  localparam int          CLK_HZ          = 100_000_000;
  localparam logic [2:0]  ERR_ALL         = 3'h7;
  localparam logic [15:0] ZERO16          = 16'h0000;

  // error codes
  typedef enum logic [2:0] {
    BSF_ERR_OK       = 3'h0,
    BSF_ERR_BUSY     = 3'h1,
    BSF_ERR_RESERVED = 3'h2,
    BSF_ERR_UNSUPP   = 3'h3,
    BSF_ERR_DENIED   = 3'h4,
    BSF_ERR_OVERFLOW = 3'h5,
    BSF_ERR_BADSIZE  = 3'h6,
    BSF_ERR_UNKNOWN  = 3'h7
  } bsf_err_e;

  // command classification
  typedef enum logic [2:0] {
    BSF_CLS_RW       = 3'h0,
    BSF_CLS_RO       = 3'h1,
    BSF_CLS_RESERVED = 3'h3,
    BSF_CLS_UNSUPP   = 3'h2,
    BSF_CLS_MFG_OPT  = 3'h6
  } bsf_cls_e;

  // measured values from the gauge core
  typedef struct packed {
    logic [15:0] remaining_charge;     // mAh or 10 mWh
    logic [15:0] remaining_cap_power;  // same in other unit
    logic [15:0] avg_time_current;     // minutes, current based
    logic [15:0] avg_time_power;       // minutes, power based
    logic [15:0] voltage;              // pack mV
    logic [15:0] cell_voltage;         // lowest cell mV
    logic [15:0] current_abs;          // discharge magnitude mA
    logic [15:0] temperature;          // 0.1 K
    logic [7:0]  rel_soc;              // percent
    logic        cell_low_voltage_flag;
    logic        charge_param_bad;
    logic        charge_terminated;
    logic        over_charge_cond;
    logic        charge_seen;
    logic        discharge_seen;
    logic        charge_increment;     // one pulse per counted unit of charge
    logic        load_ok;
    logic        load_bad;
  } bsf_meas_s;

  // thresholds and settings
  typedef struct packed {
    logic [15:0] max_temperature_limit;
    logic [15:0] final_empty_voltage;
    logic [15:0] second_empty_voltage;
    logic [15:0] overload_current_limit;
    logic [15:0] cap_alarm_level;
    logic [15:0] time_alarm_level;
    logic [15:0] cycle_thresh;
    logic [15:0] design_capacity;
    logic [15:0] design_capacity_pwr;
    logic [15:0] design_voltage;
    logic [7:0]  digital_filter;
    logic [7:0]  full_clear_pct;
    logic [7:0]  battery_low_pct;
    logic        capacity_mode;
    logic        use_cell_voltage;
  } bsf_cfg_s;

  // one command from the bus engine
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       size_bad;
    logic       overflow;
    logic       busy;
    logic       unknown;
    logic [7:0] code;
  } bsf_cmd_s;
endpackage

// *** verif/battery_status_flags_test.sv ***
// Purpose: self-checking bench for the battery status flag block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   second tick shortened to 10 cycles, filter 100 gives short timeouts
`timescale 1ns/1ns
module battery_status_flags_test;
  import bsf_pkg::*;
  localparam int TICK = 10;  // cycles per second tick
  typedef struct packed {
    logic [7:0] code;
    logic       wr;
    bsf_cls_e   cls;
    logic [3:0] flt;
    logic [2:0] exp;
  } bsf_row_s;
  // code, write, class, faults {size,over,busy,unknown}, expected error
  localparam bsf_row_s ROWS [10] = '{
    '{8'h16, 1'b0, BSF_CLS_RO, 4'h0, 3'h0}, '{8'h16, 1'b0, BSF_CLS_RO, 4'h2, 3'h1},
    '{8'h30, 1'b0, BSF_CLS_RESERVED, 4'h0, 3'h2}, '{8'h3f, 1'b1, BSF_CLS_MFG_OPT, 4'h0, 3'h2},
    '{8'h30, 1'b0, BSF_CLS_RESERVED, 4'h2, 3'h1}, '{8'h1d, 1'b0, BSF_CLS_UNSUPP, 4'h0, 3'h3},
    '{8'h17, 1'b1, BSF_CLS_RO, 4'h0, 3'h4}, '{8'h44, 1'b1, BSF_CLS_RW, 4'h4, 3'h5},
    '{8'h44, 1'b1, BSF_CLS_RW, 4'h8, 3'h6}, '{8'h44, 1'b1, BSF_CLS_RW, 4'h1, 3'h7}};
  logic        CLOCK = 1'b0;
  logic        RSTN = 1'b0;
  bsf_meas_s   MEAS;
  bsf_cfg_s    CFG;
  bsf_cmd_s    CMD;
  bsf_cls_e    CMD_CLASS;
  logic [15:0] NV_CYCLE_INIT, READ_DATA, STATUS_WORD, ALARM_WORD, NV_DATA, rd;
  logic        NV_INIT_VALID, ALARM_SEND, READ_VALID, ALARM_VALID, NV_WRITE, rv;
  logic [7:0]  NV_ADDR;
  logic [2:0]  er;
  int          miscompares = 0;
  int          total_checks = 0;

  always #5 CLOCK = ~CLOCK;
  bsf_flags #(.SEC_TICK_CYCLES(TICK)) u_bsf_flags (.CLOCK(CLOCK), .RSTN(RSTN), .MEAS(MEAS),
    .CFG(CFG), .CMD(CMD), .CMD_CLASS(CMD_CLASS), .NV_CYCLE_INIT(NV_CYCLE_INIT),
    .NV_INIT_VALID(NV_INIT_VALID), .ALARM_SEND(ALARM_SEND), .READ_DATA(READ_DATA),
    .READ_VALID(READ_VALID), .STATUS_WORD(STATUS_WORD), .ALARM_WORD(ALARM_WORD),
    .ALARM_VALID(ALARM_VALID), .NV_WRITE(NV_WRITE), .NV_ADDR(NV_ADDR), .NV_DATA(NV_DATA));
  bsf_host_model u_bsf_host_model (.CLOCK(CLOCK), .READ_VALID(READ_VALID),
    .READ_DATA(READ_DATA), .STATUS_WORD(STATUS_WORD), .CMD(CMD), .CMD_CLASS(CMD_CLASS));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // two edges let a registered flag land
  task automatic flag(input int b, input logic v, input string what, input int n = 2);
    step(n);
    chk({15'h0, STATUS_WORD[b]}, {15'h0, v}, what);
  endtask
  task automatic rdw(input logic [7:0] code, input logic [15:0] exp);
    u_bsf_host_model.xfer(code, 1'b0, BSF_CLS_RO, 4'h0, rv, rd, er);
    chk({15'h0, rv}, 16'h0001, "read valid");
    chk(rd, exp, "read data");
  endtask
  // two counted charge units make one cycle
  task automatic bump(input logic [15:0] exp, input logic look);
    int seen;
    seen = 0;
    for (int k = 0; k < 8; k++) begin
      MEAS.charge_increment = (k == 0 || k == 2);
      step(1);
      if (NV_WRITE === 1'b1) begin
        seen++;
        chk(NV_DATA, exp, "write back data");
      end
    end
    if (look)
      chk(16'(seen), 16'h0001, "write back count");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog sized well past the longest idle timeout
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    stop_test();
  end

  initial begin
    MEAS = '0;
    CFG = '0;
    NV_CYCLE_INIT = 16'h0000;
    NV_INIT_VALID = 1'b0;
    ALARM_SEND = 1'b0;
    MEAS.remaining_charge = 16'h03e8;
    MEAS.voltage = 16'h0fa0;
    MEAS.temperature = 16'h0bb8;
    MEAS.rel_soc = 8'h32;
    MEAS.avg_time_current = 16'h0200;
    CFG.max_temperature_limit = 16'h0c80;
    CFG.final_empty_voltage = 16'h0bb8;
    CFG.cycle_thresh = 16'h0002;
    CFG.design_capacity = 16'h07d0;
    CFG.design_capacity_pwr = 16'h0bb8;
    CFG.design_voltage = 16'h3a98;
    CFG.digital_filter = 8'h64;
    CFG.full_clear_pct = 8'h28;
    CFG.battery_low_pct = 8'h0a;
    step(5);
    chk(STATUS_WORD, 16'h0000, "word in reset");
    RSTN = 1'b1;
    step(1);
    chk(STATUS_WORD, 16'h0000, "word after reset");
    MEAS.load_ok = 1'b1;
    step(1);
    MEAS.load_ok = 1'b0;
    MEAS.load_bad = 1'b1;
    flag(BIT_LOADED, 1'b1, "loaded", 0);
    flag(BIT_LOADED, 1'b0, "load bad", 1);
    MEAS.load_bad = 1'b0;
    MEAS.load_ok = 1'b1;
    step(1);
    MEAS.load_ok = 1'b0;
    MEAS.temperature = CFG.max_temperature_limit;
    flag(BIT_OVER_TEMP, 1'b1, "over temp");
    ALARM_SEND = 1'b1;
    step(1);
    ALARM_SEND = 1'b0;
    chk({15'h0, ALARM_VALID}, 16'h0001, "alarm valid");
    chk(ALARM_WORD, 16'h1087, "alarm word");
    MEAS.temperature = 16'h0c7f;
    flag(BIT_OVER_TEMP, 1'b0, "temp back");
    for (int i = 0; i < 4; i++) begin
      MEAS.remaining_charge = (i == 0) ? 16'h0000 : 16'h03e8;
      MEAS.voltage = (i == 1) ? CFG.final_empty_voltage : 16'h0fa0;
      MEAS.cell_low_voltage_flag = (i == 2);
      flag(BIT_STOP_DISCH, i < 3, "stop discharge");
    end
    foreach (ROWS[i]) begin
      u_bsf_host_model.xfer(ROWS[i].code, ROWS[i].wr, ROWS[i].cls, ROWS[i].flt, rv, rd, er);
      chk({13'h0, er}, {13'h0, ROWS[i].exp}, "error code");
    end
    rdw(CMD_DESIGN_VOLT, 16'h3a98);
    rdw(CMD_DESIGN_CAP, 16'h07d0);
    CFG.capacity_mode = 1'b1;
    rdw(CMD_DESIGN_CAP, 16'h0bb8);
    CFG.capacity_mode = 1'b0;
    NV_CYCLE_INIT = 16'hfffd;
    NV_INIT_VALID = 1'b1;
    step(1);
    NV_INIT_VALID = 1'b0;
    rdw(CMD_CYCLE_COUNT, 16'hfffd);
    bump(16'hfffe, 1'b1);
    bump(16'hffff, 1'b1);
    bump(16'hffff, 1'b0);
    rdw(CMD_CYCLE_COUNT, 16'hffff);
    MEAS.charge_seen = 1'b1;
    MEAS.over_charge_cond = 1'b1;
    MEAS.charge_param_bad = 1'b1;
    flag(BIT_OVER_CHARGED, 1'b1, "overcharge");
    chk({15'h0, STATUS_WORD[BIT_FULL]}, 16'h0001, "full");
    chk({15'h0, STATUS_WORD[BIT_STOP_CHARGE]}, 16'h0001, "stop charge");
    chk({15'h0, STATUS_WORD[BIT_DISCHARGING]}, 16'h0000, "charging");
    MEAS.charge_param_bad = 1'b0;
    flag(BIT_STOP_CHARGE, 1'b0, "param back");
    MEAS.charge_seen = 1'b0;
    MEAS.over_charge_cond = 1'b0;
    flag(BIT_DISCHARGING, 1'b0, "no charge early", 2200);
    flag(BIT_DISCHARGING, 1'b1, "no charge late", 100);
    flag(BIT_OVER_CHARGED, 1'b1, "idle early", 7600);
    flag(BIT_OVER_CHARGED, 1'b0, "idle late", 200);
    MEAS.rel_soc = CFG.full_clear_pct;
    flag(BIT_FULL, 1'b0, "full clear");
    MEAS.rel_soc = 8'h05;
    flag(BIT_EMPTY, 1'b1, "empty");
    MEAS.rel_soc = 8'h13;
    flag(BIT_EMPTY, 1'b1, "empty holds");
    MEAS.rel_soc = 8'h14;
    flag(BIT_EMPTY, 1'b0, "empty clear");
    CFG.cap_alarm_level = 16'h03e8;
    MEAS.remaining_charge = 16'h03e7;
    flag(BIT_CAP_ALARM, 1'b1, "capacity alarm");
    MEAS.remaining_charge = 16'h03e9;
    flag(BIT_CAP_ALARM, 1'b0, "capacity clear");
    CFG.capacity_mode = 1'b1;
    flag(BIT_CAP_ALARM, 1'b1, "power alarm");
    CFG.capacity_mode = 1'b0;
    CFG.time_alarm_level = 16'h0064;
    MEAS.avg_time_current = 16'h0063;
    flag(BIT_TIME_ALARM, 1'b1, "time alarm");
    MEAS.avg_time_current = 16'h0065;
    flag(BIT_TIME_ALARM, 1'b0, "time clear");
    stop_test();
  end
endmodule // battery_status_flags_test

// *** verif/bsf_flags_checker.sv ***
// Purpose: port level assertions for the flag block
// Assumes: one clock, reset active low
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
module bsf_flags_checker
  import bsf_pkg::*;
#(
  parameter int SEC_TICK_CYCLES = CLK_HZ   // kept in step with the block
) (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire bsf_meas_s   MEAS,
  input wire bsf_cfg_s    CFG,
  input wire bsf_cmd_s    CMD,
  input wire bsf_cls_e    CMD_CLASS,
  input wire logic        ALARM_SEND,
  input wire logic [15:0] READ_DATA,
  input wire logic        READ_VALID,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [15:0] ALARM_WORD,
  input wire logic        ALARM_VALID,
  input wire logic        NV_WRITE,
  input wire logic [7:0]  NV_ADDR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  logic rd_ok;  // a read of one of the answered words
  assign rd_ok = CMD.valid && !CMD.write && !CMD.busy
                 && CMD.code >= CMD_STATUS && CMD.code <= CMD_DESIGN_VOLT;

  ////////////////////////////////////////////////////////////////////////////////
  rsvd_zero_a: assert property (!STATUS_WORD[BIT_RSVD_HI] && !STATUS_WORD[BIT_RSVD_LO])
    else $error("reserved status bit set");
  read_answer_a: assert property (rd_ok |=> READ_VALID)
    else $error("read not answered");
  read_cause_a: assert property (READ_VALID |-> $past(rd_ok))
    else $error("answer without read");
  volt_word_a: assert property (rd_ok && CMD.code == CMD_DESIGN_VOLT
    |=> READ_DATA == $past(CFG.design_voltage)) else $error("design voltage wrong");
  cap_word_a: assert property (rd_ok && CMD.code == CMD_DESIGN_CAP |=> READ_DATA ==
    ($past(CFG.capacity_mode) ? $past(CFG.design_capacity_pwr) : $past(CFG.design_capacity)))
    else $error("design capacity wrong");
  busy_code_a: assert property (CMD.valid && CMD.busy |=> STATUS_WORD[2:0] == 3'h1)
    else $error("busy code wrong");
  denied_code_a: assert property (CMD.valid && CMD.write && !CMD.busy
    && CMD_CLASS == BSF_CLS_RO |=> STATUS_WORD[2:0] == 3'h4) else $error("denied code wrong");
  alarm_word_a: assert property (ALARM_SEND |=> ALARM_VALID && ALARM_WORD[2:0] == ERR_ALL)
    else $error("alarm word wrong");
  over_temp_a: assert property (MEAS.temperature >= CFG.max_temperature_limit
    |=> STATUS_WORD[BIT_OVER_TEMP]) else $error("over temperature missed");
  stop_disch_a: assert property ((MEAS.remaining_charge == ZERO16 || MEAS.cell_low_voltage_flag
    || MEAS.voltage <= CFG.final_empty_voltage) |=> STATUS_WORD[BIT_STOP_DISCH])
    else $error("stop discharge missed");
  nv_addr_a: assert property (NV_WRITE |-> NV_ADDR == NV_CYCLE_COUNT)
    else $error("write back address wrong");
  loaded_set_a: assert property (MEAS.load_ok |=> STATUS_WORD[BIT_LOADED])
    else $error("loaded flag missed");
  // main scenarios reached
  read_seen_c: cover property (rd_ok ##1 READ_VALID);
  alarm_seen_c: cover property (ALARM_SEND ##1 ALARM_VALID);
  nv_seen_c: cover property (NV_WRITE);
endmodule // bsf_flags_checker

bind bsf_flags bsf_flags_checker #(.SEC_TICK_CYCLES(SEC_TICK_CYCLES)) u_bsf_flags_checker (
  .CLOCK(CLOCK), .RSTN(RSTN), .MEAS(MEAS), .CFG(CFG), .CMD(CMD), .CMD_CLASS(CMD_CLASS),
  .ALARM_SEND(ALARM_SEND), .READ_DATA(READ_DATA), .READ_VALID(READ_VALID),
  .STATUS_WORD(STATUS_WORD), .ALARM_WORD(ALARM_WORD), .ALARM_VALID(ALARM_VALID),
  .NV_WRITE(NV_WRITE), .NV_ADDR(NV_ADDR));

// *** verif/bsf_host_model.sv ***
// Purpose: host side model issuing word commands to the flag block
// Assumes: requests change 1 ns after the rising edge
// Notes:   answer is taken one cycle after the request edge
`timescale 1ns/1ns
module bsf_host_model
  import bsf_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        READ_VALID,
  input  wire logic [15:0] READ_DATA,
  input  wire logic [15:0] STATUS_WORD,
  output bsf_cmd_s         CMD,
  output bsf_cls_e         CMD_CLASS
);
  // idle bus at time zero
  initial begin
    CMD = '0;
    CMD_CLASS = BSF_CLS_RW;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one request pulse; flt is size_bad, overflow, busy, unknown
  task automatic xfer(input logic [7:0] code, input logic wr, input bsf_cls_e cls,
                      input logic [3:0] flt, output logic rv, output logic [15:0] rd,
                      output logic [2:0] er);
    @(posedge CLOCK);
    #1;
    CMD = {1'b1, wr, flt, code};
    CMD_CLASS = cls;
    @(posedge CLOCK);
    #1;
    rv = READ_VALID;
    rd = READ_DATA;
    er = STATUS_WORD[2:0];
    CMD.valid = 1'b0;
    // released code flips so a stale value never looks valid
    CMD.code = ~code;
  endtask
endmodule // bsf_host_model
